//--- verilog/ebn_nand_ctrl.sv
// Expansion bus controller: NAND path, chip selects, boot width, clock, reset
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - NAND mode only on the dedicated path
// - NAND mode when address-latch and strobe bits zero
// - One strobe toggle per whole expansion cycle
// - Write to NAND window starts a write cycle
// - Flash read strobe, polarity configurable, default low
// - Flash write strobe, may become extra select
// - Flash busy holds the strobe phase
// - Bus size 00 8-bit, 01 16-bit
// - Address first with latch pulse, then data
// - Flash strobes idle on chip select accesses
// - Boot select enabled after reset, normal mode
// - Boot width comes from two pins
// - Divide bus clock by 3 to 7
// - Reference clock in reset, divided after
// - Peripheral clock runs by default
// - Cycle timing counted in divided periods
// - Reset clears the block logic
// - Self-clearing soft reset keeps configuration
// - Clearing clock enable stops peripheral clock
module ebn_nand_ctrl (
  input  wire logic                        clk,
  input  wire logic                        srst,
  input  wire logic                        soft_rst_req,
  input  wire logic                        cfg_ale_mode,
  input  wire logic                        cfg_command_strobe_mode_bit,
  input  wire logic [1:0]                  cfg_bus_size,
  input  wire logic                        cfg_re_pol,
  input  wire logic                        cfg_we_pol,
  input  wire logic                        cfg_we_as_cs,
  input  wire logic [ebn_pkg::DIV_W-1:0]   cfg_clk_div,
  input  wire logic                        cfg_clk_en,
  input  wire logic [ebn_pkg::TIM_W-1:0]   cfg_t_setup,
  input  wire logic [ebn_pkg::TIM_W-1:0]   cfg_t_strobe,
  input  wire logic [ebn_pkg::TIM_W-1:0]   cfg_t_hold,
  input  wire logic                        cfg_cs0_off,
  input  wire logic [1:0]                  boot_width_pins,
  input  wire logic                        req_valid,
  output logic                             req_ready,
  input  wire logic                        req_nand,
  input  wire logic                        req_write,
  input  wire logic [ebn_pkg::CS_W-1:0]    req_cs,
  input  wire logic [ebn_pkg::ADDR_W-1:0]  req_addr,
  input  wire logic [ebn_pkg::DATA_W-1:0]  req_wdata,
  output logic                             rsp_valid,
  output logic                             rsp_err,
  output logic [ebn_pkg::DATA_W-1:0]       rsp_rdata,
  output logic                             periph_clk,
  output logic                             exp_ale,
  output logic [ebn_pkg::ADDR_W-1:0]       exp_addr,
  output logic [ebn_pkg::CS_N-1:0]         cs_n,
  output logic                             exp_re_n,
  output logic                             exp_we_n,
  output logic                             flash_read_strobe_n,
  output logic                             flash_write_strobe_n,
  output logic [ebn_pkg::DATA_W-1:0]       data_o,
  output logic [1:0]                       data_oe_n,
  input  wire logic [ebn_pkg::DATA_W-1:0]  data_i,
  input  wire logic                        flash_rdy,
  output logic [1:0]                       boot_width,
  output logic                             busy,
  output logic                             soft_rst_active
);

  ebn_pkg::ebn_state_t st_r;

  logic                            soft_rst_r;
  logic                            logic_rst;
  logic                            tick;
  logic                            rdy_s;
  logic [ebn_pkg::DATA_W-1:0]      data_s;
  logic [1:0]                      boot_pins_s;
  logic [1:0]                      boot_width_r;
  logic                            boot_cs_en_r;
  logic [ebn_pkg::TIM_W-1:0]       cnt_r;
  logic                            phase_done;
  logic                            nand_r;
  logic                            wr_r;
  logic                            we_cs_r;
  logic                            wide_r;
  logic [ebn_pkg::CS_W-1:0]        cs_r;
  logic [ebn_pkg::ADDR_W-1:0]      addr_r;
  logic [ebn_pkg::DATA_W-1:0]      wdata_r;
  logic [1:0]                      size_sel;
  logic                            nand_mode;
  logic                            req_bad;
  logic                            nand_path;
  logic                            strb_on;
  logic                            drv_addr;
  logic                            drv_data;
  logic                            rdy_ok;
  logic [1:0]                      rd_cap_r;

  // Self-clearing soft reset: a single-cycle pulse, merged with the pin reset
  always_ff @(posedge clk) begin
    if (srst) begin
      soft_rst_r <= 1'b0;
    end else begin
      soft_rst_r <= soft_rst_req && !soft_rst_r;
    end
  end

  // Pin reset is synchronised outside the block
  assign logic_rst       = srst || soft_rst_r;
  assign soft_rst_active = soft_rst_r;

  ebn_clk_gen u_clk_gen (
    .clk        (clk),
    .srst       (srst),
    .logic_rst  (logic_rst),
    .div_sel    (cfg_clk_div),
    .clk_en     (cfg_clk_en),
    .periph_clk (periph_clk),
    .tick       (tick)
  );

  ebn_sync #(.W(1)) u_sync_rdy (
    .clk    (clk),
    .srst   (srst),
    .pin_i  (flash_rdy),
    .sync_o (rdy_s)
  );

  ebn_sync #(.W(ebn_pkg::DATA_W)) u_sync_data (
    .clk    (clk),
    .srst   (srst),
    .pin_i  (data_i),
    .sync_o (data_s)
  );

  ebn_sync #(.W(2)) u_sync_boot (
    .clk    (clk),
    .srst   (1'b0), // Pins must pass through while reset holds
    .pin_i  (boot_width_pins),
    .sync_o (boot_pins_s)
  );

  // Boot width is sampled while reset is held; soft reset leaves it alone
  always_ff @(posedge clk) begin
    if (srst) begin
      boot_width_r <= boot_pins_s;
    end
  end

  assign boot_width = boot_width_r;

  // Boot select starts enabled; software may switch it off later
  always_ff @(posedge clk) begin
    if (srst) begin
      boot_cs_en_r <= ebn_pkg::BOOT_CS_RST;
    end else if (cfg_cs0_off) begin
      boot_cs_en_r <= 1'b0;
    end
  end

  // Both mode bits at zero select NAND; reset defaults give exactly that
  assign nand_mode = !cfg_ale_mode && !cfg_command_strobe_mode_bit;

  // Boot select takes its width from the pins, others from software
  assign size_sel = (!req_nand && req_cs == ebn_pkg::BOOT_CS) ?
                    boot_width_r : cfg_bus_size;

  // Refuse reserved widths, NAND outside NAND mode unless the write strobe is a select, disabled boot select
  always_comb begin
    req_bad = 1'b0;
    if (size_sel != ebn_pkg::BUS_8 && size_sel != ebn_pkg::BUS_16) begin
      req_bad = 1'b1;
    end
    if (req_nand && !cfg_we_as_cs && !nand_mode) begin
      req_bad = 1'b1;
    end
    if (!req_nand && req_cs == ebn_pkg::BOOT_CS && !boot_cs_en_r) begin
      req_bad = 1'b1;
    end
  end

  assign req_ready = (st_r == ebn_pkg::ST_IDLE) && !logic_rst;
  assign busy      = (st_r != ebn_pkg::ST_IDLE);

  // Flash ready gates only the dedicated NAND path
  assign nand_path = nand_r && !we_cs_r;
  assign rdy_ok    = !nand_path || rdy_s;

  // A phase ends when its count of divided periods has run out
  assign phase_done = tick && (cnt_r <= ebn_pkg::TIM_ONE);

  // Request capture; chip select accesses never carry the NAND flag
  always_ff @(posedge clk) begin
    if (logic_rst) begin
      nand_r  <= 1'b0;
      wr_r    <= 1'b0;
      we_cs_r <= 1'b0;
      wide_r  <= 1'b0;
      cs_r    <= '0;
      addr_r  <= '0;
      wdata_r <= '0;
    end else if (req_valid && req_ready && !req_bad) begin
      nand_r  <= req_nand;
      wr_r    <= req_write;
      we_cs_r <= req_nand && cfg_we_as_cs;
      wide_r  <= (size_sel == ebn_pkg::BUS_16);
      cs_r    <= req_cs;
      addr_r  <= req_addr;
      wdata_r <= req_wdata;
    end
  end

  // Access sequence: latch, address hold, strobe, recovery
  always_ff @(posedge clk) begin
    if (logic_rst) begin
      st_r  <= ebn_pkg::ST_IDLE;
      cnt_r <= ebn_pkg::TIM_ZERO;
    end else begin
      if (tick && cnt_r != ebn_pkg::TIM_ZERO) begin
        cnt_r <= cnt_r - ebn_pkg::TIM_ONE;
      end
      case (st_r)
        ebn_pkg::ST_IDLE: begin
          if (req_valid && !req_bad) begin
            st_r  <= ebn_pkg::ST_ALE;
            cnt_r <= cfg_t_setup;
          end
        end
        ebn_pkg::ST_ALE: begin
          if (phase_done) begin
            st_r  <= ebn_pkg::ST_AHOLD;
            cnt_r <= cfg_t_hold;
          end
        end
        ebn_pkg::ST_AHOLD: begin
          if (phase_done) begin
            st_r  <= ebn_pkg::ST_STRB;
            cnt_r <= cfg_t_strobe;
          end
        end
        ebn_pkg::ST_STRB: begin
          if (phase_done && rdy_ok) begin
            st_r  <= ebn_pkg::ST_RECOV;
            cnt_r <= cfg_t_hold;
          end
        end
        ebn_pkg::ST_RECOV: begin
          if (phase_done) begin
            st_r <= ebn_pkg::ST_IDLE;
          end
        end
        default: begin
          st_r <= ebn_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Phase decode feeding the registered pins
  assign strb_on  = (st_r == ebn_pkg::ST_STRB);
  assign drv_addr = (st_r == ebn_pkg::ST_ALE) || (st_r == ebn_pkg::ST_AHOLD);
  assign drv_data = wr_r && (strb_on || st_r == ebn_pkg::ST_RECOV);

  // Answer: one pulse on refusal or at the end of recovery
  always_ff @(posedge clk) begin
    if (logic_rst) begin
      rsp_valid <= 1'b0;
      rsp_err   <= 1'b0;
    end else begin
      rsp_valid <= (req_valid && req_ready && req_bad) ||
                   (st_r == ebn_pkg::ST_RECOV && phase_done);
      rsp_err   <= req_valid && req_ready && req_bad;
    end
  end

  // Read data is taken two clocks after the strobe ends, once the synchroniser
  // shows what the flash drove; narrow bus zero-fills the upper byte
  always_ff @(posedge clk) begin
    if (logic_rst) begin
      rd_cap_r  <= '0;
      rsp_rdata <= '0;
    end else begin
      rd_cap_r <= {rd_cap_r[0], strb_on && phase_done && rdy_ok && !wr_r};
      if (rd_cap_r[1]) begin
        rsp_rdata <= wide_r ? data_s : {8'h00, data_s[7:0]};
      end
    end
  end

  // Multiplexed bus: address first under the latch pulse, then data
  always_ff @(posedge clk) begin
    if (logic_rst) begin
      exp_ale   <= 1'b0;
      exp_addr  <= '0;
      data_o    <= '0;
      data_oe_n <= 2'h3;
    end else begin
      exp_ale  <= (st_r == ebn_pkg::ST_ALE);
      exp_addr <= addr_r;
      if (drv_addr) begin
        data_o    <= addr_r[ebn_pkg::DATA_W-1:0];
        data_oe_n <= {!wide_r, 1'b0};
      end else if (drv_data) begin
        data_o    <= wdata_r;
        data_oe_n <= {!wide_r, 1'b0};
      end else begin
        data_oe_n <= 2'h3;
      end
    end
  end

  // Chip selects are active low and follow the whole access
  for (genvar i = 0; i < ebn_pkg::CS_N; i++) begin : g_cs
    always_ff @(posedge clk) begin
      if (logic_rst) begin
        cs_n[i] <= 1'b1;
      end else begin
        cs_n[i] <= !(busy && !nand_r && cs_r == ebn_pkg::CS_W'(i));
      end
    end
  end

  // Generic strobes serve only chip select accesses
  always_ff @(posedge clk) begin
    if (logic_rst) begin
      exp_re_n <= 1'b1;
      exp_we_n <= 1'b1;
    end else begin
      exp_re_n <= !(strb_on && !nand_r && !wr_r);
      exp_we_n <= !(strb_on && !nand_r && wr_r);
    end
  end

  // Flash strobes toggle once per cycle; idle level follows the polarity, except the write strobe as a select, which idles high
  always_ff @(posedge clk) begin
    if (logic_rst) begin
      flash_read_strobe_n  <= (cfg_re_pol == ebn_pkg::POL_LOW);
      flash_write_strobe_n <= (cfg_we_pol == ebn_pkg::POL_LOW);
    end else begin
      flash_read_strobe_n <= !((strb_on && nand_path && !wr_r) ^ cfg_re_pol);
      if (cfg_we_as_cs) begin
        flash_write_strobe_n <= !(busy && we_cs_r);
      end else begin
        flash_write_strobe_n <= !((strb_on && nand_path && wr_r) ^ cfg_we_pol);
      end
    end
  end

  // Select and latch lines for the flash are GPIO, not produced here

endmodule

`default_nettype wire

//--- verilog/ebn_pkg.sv
// Shared constants and types of the expansion bus NAND path, clock and reset
package ebn_pkg;

  // Widths of the external bus and of the timing and divider fields
  localparam int DATA_W = 16;
  localparam int ADDR_W = 24;
  localparam int CS_N   = 4;
  localparam int CS_W   = 2;
  localparam int TIM_W  = 4;
  localparam int DIV_W  = 3;

  // Divider limits; the smallest keeps a 200 MHz bus clock at 66.7 MHz at most
  localparam logic [DIV_W-1:0] DIV_MIN = 3'h3;
  localparam logic [DIV_W-1:0] DIV_MAX = 3'h7;
  localparam logic [DIV_W-1:0] DIV_DEF = 3'h7;
  localparam logic [DIV_W-1:0] DIV_ONE = 3'h1;

  // Bus size codes; the two upper codes are reserved
  localparam logic [1:0] BUS_8  = 2'h0;
  localparam logic [1:0] BUS_16 = 2'h1;

  // Boot chip select index and its reset enable
  localparam logic [CS_W-1:0] BOOT_CS     = 2'h0;
  localparam logic            BOOT_CS_RST = 1'b1;

  // Phase counter limits, in divided clock periods
  localparam logic [TIM_W-1:0] TIM_ZERO = 4'h0;
  localparam logic [TIM_W-1:0] TIM_ONE  = 4'h1;

  // Polarity code: zero asserts the strobe low
  localparam logic POL_LOW = 1'b0;

  // Access sequence, Gray coded from ST_IDLE to ST_RECOV
  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_ALE   = 3'h1,
    ST_AHOLD = 3'h3,
    ST_STRB  = 3'h2,
    ST_RECOV = 3'h6
  } ebn_state_t;

endpackage

//--- verilog/ebn_sync.sv
// Two-flop synchroniser for pins that come from outside the clock domain
`timescale 1ns/1ps
`default_nettype none

module ebn_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         srst,
  input  wire logic [W-1:0] pin_i,
  output logic      [W-1:0] sync_o
);

  logic [W-1:0] meta_r;

  // First stage feeds only the second stage
  always_ff @(posedge clk) begin
    if (srst) begin
      meta_r <= '0;
      sync_o <= '0;
    end else begin
      meta_r <= pin_i;
      sync_o <= meta_r;
    end
  end

endmodule

`default_nettype wire

//--- verilog/ebn_clk_gen.sv
// Divided peripheral clock generator with reset clock select and gating
`timescale 1ns/1ps
`default_nettype none

module ebn_clk_gen (
  input  wire logic                     clk,
  input  wire logic                     srst,
  input  wire logic                     logic_rst,
  input  wire logic [ebn_pkg::DIV_W-1:0] div_sel,
  input  wire logic                     clk_en,
  output logic                          periph_clk,
  output logic                          tick
);

  logic [ebn_pkg::DIV_W-1:0] div_r;
  logic [ebn_pkg::DIV_W-1:0] cnt_r;
  logic [ebn_pkg::DIV_W-1:0] div_nxt;
  logic                      level_r;
  logic                      en_r;
  logic                      sel_ref_r;
  logic                      wrap;

  // Out-of-range divide values are clamped so the clock never runs too fast
  always_comb begin
    if (div_sel < ebn_pkg::DIV_MIN) begin
      div_nxt = ebn_pkg::DIV_MIN;
    end else begin
      div_nxt = div_sel;
    end
  end

  assign wrap = (cnt_r == div_r - ebn_pkg::DIV_ONE);
  assign tick = (cnt_r == '0) && !logic_rst;

  // Divider counter; a new ratio only takes effect at a period boundary
  always_ff @(posedge clk) begin
    if (logic_rst) begin
      div_r <= ebn_pkg::DIV_DEF;
      cnt_r <= '0;
    end else if (wrap) begin
      div_r <= div_nxt;
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_r + ebn_pkg::DIV_ONE;
    end
  end

  // High for the first div_r/2 + 1 cycles of each period, div_r/2 rounded down
  always_ff @(posedge clk) begin
    if (logic_rst) begin
      level_r <= 1'b0;
    end else begin
      level_r <= wrap || (cnt_r < (div_r >> 1));
    end
  end

  // Enable changes only at the wrap, while the level is low, to avoid runts
  always_ff @(posedge clk) begin
    if (srst) begin
      en_r <= 1'b1;
    end else if (wrap) begin
      en_r <= clk_en;
    end
  end

  // Reference clock during reset, divided clock from the first edge after
  always_ff @(posedge clk) begin
    if (srst) begin
      sel_ref_r <= 1'b1;
    end else begin
      sel_ref_r <= 1'b0;
    end
  end

  // The switch may glitch once at reset release; peripherals must tolerate it
  assign periph_clk = sel_ref_r ? clk : (level_r && en_r);

endmodule

`default_nettype wire

//--- testbench/ebn_nand_ctrl_assertions.sv
// Port checker for the expansion bus NAND controller
`timescale 1ns/1ps
`default_nettype none

module ebn_nand_ctrl_assertions (
  input wire logic        clk,
  input wire logic        srst,
  input wire logic        soft_rst_req,
  input wire logic        cfg_ale_mode,
  input wire logic        cfg_command_strobe_mode_bit,
  input wire logic [1:0]  cfg_bus_size,
  input wire logic        cfg_re_pol,
  input wire logic        cfg_we_pol,
  input wire logic        cfg_we_as_cs,
  input wire logic        req_valid,
  input wire logic        req_ready,
  input wire logic        req_nand,
  input wire logic        req_write,
  input wire logic [23:0] req_addr,
  input wire logic        rsp_valid,
  input wire logic        rsp_err,
  input wire logic        exp_ale,
  input wire logic        exp_re_n,
  input wire logic        exp_we_n,
  input wire logic [23:0] exp_addr,
  input wire logic [3:0]  cs_n,
  input wire logic        flash_read_strobe_n,
  input wire logic        flash_write_strobe_n,
  input wire logic [1:0]  data_oe_n,
  input wire logic        flash_rdy,
  input wire logic        soft_rst_active
);
  default clocking dcb @(posedge clk);
  endclocking
  default disable iff (srst);

  logic        rd_on;
  logic        wr_on;
  logic        acc;
  logic        nand_go;
  logic [23:0] acc_addr_r;

  // Strobe activity is judged against the programmed polarity
  assign rd_on   = (flash_read_strobe_n == cfg_re_pol);
  assign wr_on   = (flash_write_strobe_n == cfg_we_pol);
  assign acc     = req_valid && req_ready;
  assign nand_go = acc && req_nand && !cfg_bus_size[1] && !cfg_we_as_cs
                   && !cfg_ale_mode && !cfg_command_strobe_mode_bit;

  // Keep the accepted address until the latch phase shows it
  always_ff @(posedge clk) begin
    if (acc) begin
      acc_addr_r <= req_addr;
    end
  end

  a_strobe_idle_cs: assert property (cs_n != 4'hF |-> !rd_on && !wr_on)
    else $error("flash strobe during select access");
  a_nand_no_cs: assert property (rd_on |-> cs_n == 4'hF)
    else $error("select low during flash read");
  a_busy_hold_rd: assert property ((rd_on && !flash_rdy) [*4] |=> rd_on)
    else $error("read strobe ended while busy");
  a_write_strobe_go: assert property (nand_go && req_write |-> ##[2:600] wr_on)
    else $error("no write strobe after window write");
  a_addr_latch_first: assert property (nand_go |-> ##[1:200] exp_ale && exp_addr == acc_addr_r)
    else $error("address not latched");
  a_byte_lane_8: assert property ($stable(cfg_bus_size) && cfg_bus_size == 2'h0 |-> data_oe_n[1])
    else $error("upper byte driven in 8 bit mode");
  a_size_refused: assert property (acc && cfg_bus_size[1] |=> rsp_valid && rsp_err)
    else $error("reserved size not refused");
  a_mode_refused: assert property (acc && req_nand && !cfg_we_as_cs
    && (cfg_ale_mode || cfg_command_strobe_mode_bit) |=> rsp_valid && rsp_err)
    else $error("wrong mode not refused");
  a_soft_rst_pulse: assert property ($rose(soft_rst_req) |=> soft_rst_active && !req_ready ##1 !soft_rst_active)
    else $error("soft reset pulse wrong");
  a_generic_sel: assert property (cs_n == 4'hF |-> exp_re_n && exp_we_n)
    else $error("generic strobe without select");
endmodule

`default_nettype wire

//--- testbench/ebn_flash_model.sv
// Behavioural NAND flash beside the dedicated flash strobes
`timescale 1ns/1ps
`default_nettype none

module ebn_flash_model (
  input  wire logic        clk,
  input  wire logic        re_pol,
  input  wire logic        we_pol,
  input  wire logic        re_pin,
  input  wire logic        we_pin,
  input  wire logic        cle,
  input  wire logic        ale,
  input  wire logic [15:0] dout,
  input  wire logic [1:0]  doe_n,
  input  wire logic [3:0]  slow,
  output logic      [15:0] din,
  output logic             rdy
);
  logic        rd_on;
  logic        wr_on;
  logic        on_r = 1'b0;
  logic        wr_r = 1'b0;
  logic [3:0]  wait_r = 4'h0;
  logic [15:0] cap_r = 16'h0000;
  logic [15:0] mem_r = 16'h0000;
  logic [7:0]  cmd_r = 8'h00;
  logic [15:0] addr_r = 16'h0000;

  // Strobes are judged against the programmed polarity
  assign rd_on = (re_pin == re_pol);
  assign wr_on = (we_pin == we_pol);
  assign rdy   = (wait_r == 4'h0);

  // Busy for a chosen number of cycles from each strobe start
  always @(posedge clk) begin
    on_r <= rd_on | wr_on;
    if ((rd_on | wr_on) && !on_r) begin
      wait_r <= slow;
    end else if (wait_r != 4'h0) begin
      wait_r <= wait_r - 4'h1;
    end
  end

  // Undriven lanes read as zero; a value is taken as the strobe ends
  always @(posedge clk) begin
    wr_r <= wr_on;
    if (wr_on) begin
      cap_r <= {doe_n[1] ? 8'h00 : dout[15:8], doe_n[0] ? 8'h00 : dout[7:0]};
    end
    if (wr_r && !wr_on && cle) begin
      cmd_r <= cap_r[7:0];
    end else if (wr_r && !wr_on && ale) begin
      addr_r <= {addr_r[7:0], cap_r[7:0]};
    end else if (wr_r && !wr_on) begin
      mem_r <= cap_r;
    end
  end

  // A released bus toggles so a stale value can never pass
  initial din = 16'h0000;
  always @(posedge clk) begin
    din <= rd_on ? mem_r : ~din;
  end
endmodule

`default_nettype wire

//--- testbench/ebn_nand_ctrl_tb_top.sv
// Self-checking bench for the expansion bus NAND controller
`timescale 1ns/1ps
`default_nettype none

module ebn_nand_ctrl_tb_top;
  logic        clk = 1'b0, srst = 1'b1, soft_rst_req = 1'b0, cfg_ale_mode = 1'b0;
  logic        cfg_command_strobe_mode_bit = 1'b0, cfg_re_pol = 1'b0, cfg_we_pol = 1'b0;
  logic        cfg_we_as_cs = 1'b0, cfg_clk_en = 1'b1, cfg_cs0_off = 1'b0, req_valid = 1'b0;
  logic        req_nand = 1'b0, req_write = 1'b0, cle = 1'b0, ale = 1'b0;
  logic [1:0]  cfg_bus_size = 2'h0, boot_width_pins = 2'h1, req_cs = 2'h0;
  logic [2:0]  cfg_clk_div = 3'h7;
  logic [3:0]  cfg_t_setup = 4'h1, cfg_t_strobe = 4'h1, cfg_t_hold = 4'h1, slow = 4'h0;
  logic [23:0] req_addr = 24'h000000, exp_addr;
  logic [15:0] req_wdata = 16'h0000, data_i, rsp_rdata, data_o;
  logic        req_ready, rsp_valid, rsp_err, periph_clk, exp_ale, exp_re_n, exp_we_n;
  logic        flash_rdy, busy, flash_read_strobe_n, flash_write_strobe_n, soft_rst_active;
  logic [1:0]  data_oe_n, boot_width;
  logic [3:0]  cs_n;
  int          miscompares = 0, n_checks = 0, seed = 32'hAC73, p, i;

  ebn_nand_ctrl i_ebn_nand_ctrl (.*);
  ebn_flash_model i_ebn_flash_model (.clk(clk), .re_pol(cfg_re_pol), .we_pol(cfg_we_pol),
    .re_pin(flash_read_strobe_n), .we_pin(flash_write_strobe_n), .cle(cle), .ale(ale),
    .dout(data_o), .doe_n(data_oe_n), .slow(slow), .din(data_i), .rdy(flash_rdy));

  // 40 MHz system clock
  always #12.5 clk = ~clk;

  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic print_verdict;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // A wait that runs out ends the run at once
  task automatic give_up;
    miscompares++;
    print_verdict();
  endtask

  // Hold a request over the accepting edge, then release it at the next fall
  task automatic start_req(input logic n, input logic w, input logic [1:0] c,
                           input logic [23:0] a, input logic [15:0] wd);
    int k;
    k = 0;
    while (req_ready !== 1'b1 && k < 3000) begin
      @(negedge clk);
      k++;
    end
    if (k == 3000) give_up();
    req_nand = n;
    req_write = w;
    req_cs = c;
    req_addr = a;
    req_wdata = wd;
    req_valid = 1'b1;
    @(negedge clk);
    req_valid = 1'b0;
  endtask

  task automatic wait_rsp(output int k);
    k = 0;
    while (rsp_valid !== 1'b1 && k < 3000) begin
      @(negedge clk);
      k++;
    end
    if (k == 3000) give_up();
  endtask

  task automatic do_req(input logic n, input logic w, input logic [1:0] c,
                        input logic [23:0] a, input logic [15:0] wd, output int k);
    start_req(n, w, c, a, wd);
    wait_rsp(k);
  endtask

  // Distance in system clocks between the first two rises of the peripheral clock
  task automatic meas(output int q);
    int r0;
    int k;
    logic pv;
    r0 = -1;
    q = 0;
    pv = periph_clk;
    for (k = 0; k < 40; k++) begin
      @(negedge clk);
      if (periph_clk === 1'b1 && pv === 1'b0) begin
        if (r0 >= 0 && q == 0) q = k - r0;
        r0 = k;
      end
      pv = periph_clk;
    end
  endtask

  // An 8 bit device returns only its low byte
  function automatic logic [15:0] rd_exp(input logic [15:0] v, input logic [1:0] sz);
    return (sz == ebn_pkg::BUS_16) ? v : {8'h00, v[7:0]};
  endfunction

  // Data write to the flash, then read it back
  task automatic wr_rd(input logic [15:0] v);
    int k;
    do_req(1'b1, 1'b1, 2'h0, 24'($random(seed)), v, k);
    chk(24'(k >= 3 * int'(cfg_clk_div)), 24'h1);
    do_req(1'b1, 1'b0, 2'h0, 24'h000010, 16'h0000, k);
    chk(rsp_rdata, rd_exp(v, cfg_bus_size));
    chk(rsp_err, 1'b0);
  endtask

  initial begin
    repeat (2) @(negedge clk);
    @(posedge clk);
    #1;
    chk(periph_clk, 1'b1);
    @(negedge clk);
    #1;
    chk(periph_clk, 1'b0);
    chk(cs_n, 4'hF);
    chk({data_oe_n, flash_read_strobe_n, flash_write_strobe_n}, 24'hF);
    srst = 1'b0;
    boot_width_pins = 2'h0;
    repeat (2) @(negedge clk);
    chk(boot_width, 2'h1);
    chk(req_ready, 1'b1);
    // Every ratio, plus one below range that must clamp
    for (i = 2; i < 8; i++) begin
      cfg_clk_div = i[2:0];
      repeat (20) @(negedge clk);
      meas(p);
      chk(24'(p), 24'((i < 3) ? 3 : i));
    end
    cfg_clk_en = 1'b0;
    repeat (10) @(negedge clk);
    meas(p);
    chk(24'(p), 24'h0);
    cfg_clk_en = 1'b1;
    cfg_clk_div = 3'h3;
    // Command, then a two-byte address with the latch line held across it
    cle = 1'b1;
    do_req(1'b1, 1'b1, 2'h0, 24'h000040, 16'h0090, p);
    cle = 1'b0;
    ale = 1'b1;
    do_req(1'b1, 1'b1, 2'h0, 24'h000041, 16'h00A5, p);
    do_req(1'b1, 1'b1, 2'h0, 24'h000042, 16'h005A, p);
    ale = 1'b0;
    chk(i_ebn_flash_model.cmd_r, 24'h90);
    chk(i_ebn_flash_model.addr_r, 24'hA55A);
    // Random traffic over polarity, width, timing and flash speed
    for (i = 0; i < 16; i++) begin
      cfg_re_pol = i[0];
      cfg_we_pol = i[0];
      cfg_bus_size = {1'b0, i[1]};
      slow = i[2] ? 4'h6 : 4'h0;
      cfg_clk_div = 3'h3 + 3'($unsigned($random(seed)) % 5);
      cfg_t_setup = 4'($unsigned($random(seed)) % 3);
      cfg_t_strobe = 4'h1 + 4'($unsigned($random(seed)) % 3);
      cfg_t_hold = 4'($unsigned($random(seed)) % 3);
      repeat (2) @(negedge clk);
      wr_rd(16'($random(seed)));
    end
    cfg_re_pol = 1'b0;
    cfg_we_pol = 1'b0;
    // Reserved widths, then each wrong mode pair
    for (i = 0; i < 5; i++) begin
      cfg_bus_size = (i < 2) ? 2'(2 + i) : ebn_pkg::BUS_8;
      {cfg_ale_mode, cfg_command_strobe_mode_bit} = (i < 2) ? 2'h0 : 2'(i - 1);
      do_req(1'b1, i[0], 2'h0, 24'h000001, 16'h0000, p);
      chk(rsp_err, 1'b1);
    end
    // Write strobe as an extra select works outside NAND mode
    cfg_we_as_cs = 1'b1;
    start_req(1'b1, 1'b1, 2'h0, 24'h000002, 16'h0033);
    repeat (2) @(negedge clk);
    chk(flash_write_strobe_n, 1'b0);
    wait_rsp(p);
    chk(rsp_err, 1'b0);
    cfg_we_as_cs = 1'b0;
    {cfg_ale_mode, cfg_command_strobe_mode_bit} = 2'h0;
    cfg_bus_size = ebn_pkg::BUS_16; // Other selects wide from software; boot select is wide from the pins
    for (i = 0; i < 4; i++) begin
      do_req(1'b0, i[0], i[1:0], 24'($random(seed)), 16'h00C3, p);
      chk(rsp_err, 1'b0);
    end
    cfg_cs0_off = 1'b1;
    @(negedge clk);
    cfg_cs0_off = 1'b0;
    // Soft reset in the middle of a slow read keeps the configuration
    slow = 4'hF;
    start_req(1'b1, 1'b0, 2'h0, 24'h000123, 16'h0000);
    @(negedge clk);
    soft_rst_req = 1'b1;
    @(negedge clk);
    soft_rst_req = 1'b0;
    repeat (2) @(negedge clk);
    chk(busy, 1'b0);
    chk(boot_width, 2'h1);
    do_req(1'b0, 1'b1, 2'h0, 24'h000000, 16'h0000, p);
    chk(rsp_err, 1'b1);
    slow = 4'h0;
    wr_rd(16'hBEEF);
    print_verdict();
  end
endmodule

bind ebn_nand_ctrl ebn_nand_ctrl_assertions i_ebn_nand_ctrl_assertions (.*);

`default_nettype wire
